// ===== verification/ipc_irq_prio_pend_bench.sv
// Self-checking bench for the priority and pending controller
`default_nettype none
module ipc_irq_prio_pend_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ipc_pkg::*;

  localparam int N = 8;
  typedef struct packed {logic rd; logic [31:0] data; logic err;} ipc_note_type;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [11:0] bus_addr = 12'h000;
  logic [31:0] bus_wdata = 32'h0;
  logic [3:0]  bus_byte_en = 4'hf;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic        bus_priv = 1'b0;
  logic [31:0] bus_rdata;
  logic        bus_err;
  logic [N-1:0] irq_req, lvl_set = '0, pulse_set = '0;
  logic        go_enter = 1'b0, go_return = 1'b0, core_enter, core_return;
  logic [7:0]  go_id = 8'h00, core_enter_id, core_return_id, take_id, take_prio;
  logic        take_valid;
  logic        chk_due = 1'b0;
  logic [31:0] seed = 32'd29;
  ipc_note_type notes[$];
  int          n_fail = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [11:0] rst_addr[7] = '{12'h400, 12'h100, 12'h200, 12'h300, 12'hd10, 12'hf00, 12'h800};

  // Clock, 25 ns period
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  ipc_irq_prio_pend #(.NUM_IRQ(N), .PRIO_BITS(4)) dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_byte_en(bus_byte_en), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_priv(bus_priv),
    .bus_rdata(bus_rdata), .bus_err(bus_err), .irq_req(irq_req), .irq_level_sel(8'h40),
    .core_enter(core_enter), .core_enter_id(core_enter_id), .core_return(core_return),
    .core_return_id(core_return_id), .take_valid(take_valid), .take_id(take_id),
    .take_prio(take_prio));

  ipc_partner #(.N(N)) partner_u (
    .sys_clk(sys_clk), .resetn(resetn), .lvl_set(lvl_set), .pulse_set(pulse_set),
    .go_enter(go_enter), .go_return(go_return), .go_id(go_id), .irq_req(irq_req),
    .core_enter(core_enter), .core_enter_id(core_enter_id), .core_return(core_return),
    .core_return_id(core_return_id));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One bus strobe; the expected answer goes into the note queue
  // callers pass word-aligned addresses only, bits 1:0 zero
  task automatic acc(input logic r, input logic [11:0] a, input logic [31:0] d,
                     input logic p, input logic e, input logic [3:0] be = 4'hf);
    @(posedge sys_clk);
    bus_wr      <= !r;
    bus_rd      <= r;
    bus_addr    <= a;
    bus_wdata   <= r ? 32'h0 : d;
    bus_byte_en <= be;
    bus_priv    <= p;
    notes.push_back('{r, d, e});
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
  endtask : acc

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : step

  task automatic pulse(input int i);
    @(posedge sys_clk);
    pulse_set <= 8'h01 << i;
    @(posedge sys_clk);
    pulse_set <= '0;
    step(4);
  endtask : pulse

  // Handler entry when en is high, return otherwise
  task automatic core(input logic en, input logic [7:0] id);
    @(posedge sys_clk);
    go_enter  <= en;
    go_return <= !en;
    go_id     <= id;
    @(posedge sys_clk);
    go_enter  <= 1'b0;
    go_return <= 1'b0;
    step(4);
  endtask : core

  // Pending and active vectors read back
  task automatic st(input logic [31:0] p, input logic [31:0] a);
    acc(1'b1, 12'h200, p, 1'b1, 1'b0);
    acc(1'b1, 12'h300, a, 1'b1, 1'b0);
  endtask : st

  task automatic tk(input logic v, input logic [7:0] pr, input logic [7:0] id);
    // Look mid-cycle, where the registered take outputs have settled
    @(negedge sys_clk);
    chk({15'h0, take_valid, v ? take_prio : 8'h00, v ? take_id : 8'h00}, {15'h0, v, pr, id});
  endtask : tk

  // Result watcher: the cycle after each strobe holds its answer
  always @(posedge sys_clk) begin
    ipc_note_type nt;
    if (chk_due && notes.size() > 0) begin
      nt = notes.pop_front();
      chk({31'h0, bus_err}, {31'h0, nt.err});
      if (nt.rd) begin
        chk(bus_rdata, nt.data);
      end
    end
    chk_due <= bus_wr | bus_rd;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    logic [31:0] d, d2;
    step(8);
    resetn <= 1'b1;
    step(2);
    // Reset values, write-only and unmapped places read zero
    foreach (rst_addr[k]) acc(1'b1, rst_addr[k], 32'h0, 1'b1, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      d = rnd();
      acc(1'b0, 12'h400 + 12'(4 * i), d, 1'b1, 1'b0);
      acc(1'b1, 12'h400 + 12'(4 * i), d & 32'hf0f0f0f0, 1'b1, 1'b0);
    end
    d2 = rnd();
    acc(1'b0, 12'h404, d2, 1'b1, 1'b0, 4'h4);
    acc(1'b0, 12'h404, 32'hffffffff, 1'b0, 1'b1);
    acc(1'b1, 12'h404, 32'h0, 1'b0, 1'b1);
    d = (d & 32'hf0f0f0f0 & ~32'h00ff0000) | (d2 & 32'h00f00000);
    acc(1'b1, 12'h404, d, 1'b1, 1'b0);
    $display("test priority done");
    acc(1'b0, 12'hf00, 32'h5, 1'b0, 1'b1);
    acc(1'b0, 12'hd10, 32'h1, 1'b0, 1'b1);
    acc(1'b1, 12'hd10, 32'h0, 1'b1, 1'b0);
    acc(1'b0, 12'hd10, 32'h1, 1'b1, 1'b0);
    acc(1'b0, 12'hf00, 32'h8, 1'b0, 1'b0);
    st(32'h0, 32'h0);
    acc(1'b0, 12'hf00, 32'h5, 1'b0, 1'b0);
    st(32'h20, 32'h0);
    acc(1'b0, 12'h280, 32'h20, 1'b1, 1'b0);
    acc(1'b0, 12'h200, 32'h10, 1'b1, 1'b0);
    st(32'h10, 32'h0);
    acc(1'b0, 12'h280, 32'h10, 1'b1, 1'b0);
    $display("test trigger done");
    pulse(2);
    st(32'h04, 32'h0);
    tk(1'b0, 8'h00, 8'h00);
    acc(1'b0, 12'h280, 32'h04, 1'b1, 1'b0);
    st(32'h0, 32'h0);
    acc(1'b0, 12'h404, 32'h00802000, 1'b1, 1'b0);
    acc(1'b0, 12'h100, 32'h60, 1'b1, 1'b0);
    acc(1'b0, 12'hf00, 32'h6, 1'b0, 1'b0);
    acc(1'b0, 12'hf00, 32'h5, 1'b0, 1'b0);
    step(3);
    tk(1'b1, 8'h20, 8'h05);
    acc(1'b0, 12'h404, 32'h00102000, 1'b1, 1'b0);
    step(3);
    tk(1'b1, 8'h10, 8'h06);
    acc(1'b0, 12'h180, 32'h40, 1'b1, 1'b0);
    acc(1'b1, 12'h100, 32'h20, 1'b1, 1'b0);
    tk(1'b1, 8'h20, 8'h05);
    acc(1'b0, 12'h280, 32'h60, 1'b1, 1'b0);
    $display("test urgency done");
    pulse(5);
    tk(1'b1, 8'h20, 8'h05);
    core(1'b1, 8'h05);
    st(32'h0, 32'h20);
    pulse(5);
    st(32'h20, 32'h20);
    acc(1'b0, 12'h280, 32'h20, 1'b1, 1'b0);
    st(32'h0, 32'h20);
    pulse(5);
    core(1'b0, 8'h05);
    st(32'h20, 32'h0);
    core(1'b1, 8'h05);
    core(1'b0, 8'h05);
    st(32'h0, 32'h0);
    $display("test pulse done");
    @(posedge sys_clk);
    lvl_set <= 8'h40;
    step(4);
    st(32'h40, 32'h0);
    acc(1'b0, 12'h280, 32'h40, 1'b1, 1'b0);
    st(32'h40, 32'h0);
    core(1'b1, 8'h06);
    st(32'h0, 32'h40);
    core(1'b0, 8'h06);
    st(32'h40, 32'h0);
    core(1'b1, 8'h06);
    lvl_set <= 8'h00;
    core(1'b0, 8'h06);
    st(32'h0, 32'h0);
    lvl_set <= 8'h40;
    step(4);
    lvl_set <= 8'h00;
    step(3);
    acc(1'b0, 12'h280, 32'h40, 1'b1, 1'b0);
    st(32'h0, 32'h0);
    $display("test level done");
    step(2);
    give_verdict();
  end
endmodule : ipc_irq_prio_pend_bench
`default_nettype wire

// ===== verification/ipc_partner.sv
// Model of the peripheral request lines and the core handler handshake
`default_nettype none
module ipc_partner #(
  parameter int N = 8
) (
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         resetn,
  // Bench commands
  input  wire logic [N-1:0]                 lvl_set,
  input  wire logic [N-1:0]                 pulse_set,
  input  wire logic                         go_enter,
  input  wire logic                         go_return,
  input  wire logic [ipc_pkg::IPC_ID_W-1:0] go_id,
  // Towards the controller
  output logic      [N-1:0]                 irq_req,
  output logic                              core_enter,
  output logic      [ipc_pkg::IPC_ID_W-1:0] core_enter_id,
  output logic                              core_return,
  output logic      [ipc_pkg::IPC_ID_W-1:0] core_return_id
);
  timeunit 1ns;
  timeprecision 1ps;
  import ipc_pkg::*;

  // pulse and level lines
  // A pulse lasts exactly one clock; a level line stays up until the bench drops it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_req <= '0;
    end else begin
      irq_req <= lvl_set | pulse_set;
    end
  end

  // Handler entry and return, one-cycle strobes
  // Ids are inverted every cycle outside a strobe, so a stale id comes back on every other cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      core_enter     <= 1'b0;
      core_return    <= 1'b0;
      core_enter_id  <= 8'h00;
      core_return_id <= 8'h00;
    end else begin
      core_enter     <= go_enter;
      core_return    <= go_return;
      core_enter_id  <= go_enter ? go_id : ~core_enter_id;
      core_return_id <= go_return ? go_id : ~core_return_id;
    end
  end
endmodule : ipc_partner
`default_nettype wire

// ===== verilog/ipc_irq_prio_pend.sv
// Interrupt priority storage, software trigger and pending/active state machine
//
// Functional notes
// - One 8-bit priority per interrupt, four per word, byte writes accepted.
// - Lane 0 is bits 7..0 up to lane 3 at bits 31..24.
// - Smaller priority value means more urgent interrupt.
// - Only priority bits 7..n exist; lower bits read zero, writes dropped.
// - Trigger register write makes interrupt numbered in bits 8..0 pending.
// - Unprivileged trigger writes allowed only while pend permit bit is one.
// - Only privileged software may change the pend permit bit.
// - Pulse requests sampled on rising clock edge and latched.
// - Line high while not active makes interrupt pending.
// - Any rising edge on the line makes interrupt pending.
// - Set-pending bit or trigger write makes interrupt pending.
// - Handler entry clears pending and makes the interrupt active.
// - Level return: line high gives pending, else inactive.
// - Pulse during handler gives active and pending; return leaves pending.
// - No pulse during handler: return leaves the interrupt inactive.
// - Level clear-pending: no change while line high, else inactive.
// - Pulse clear-pending: pending to inactive, active-pending to active.
// - Pending is recorded even while the interrupt is disabled.
// - Only enabled pending interrupts are offered to the core.
// - Clear-pending never changes the active state.
//
// Our own choices: strobed register access and the address map.
`default_nettype none
module ipc_irq_prio_pend #(
  parameter int NUM_IRQ   = 240,
  parameter int PRIO_BITS = 4
) (
  // Clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              resetn,
  // Register port
  input  wire logic [ipc_pkg::IPC_ADDR_W-1:0]    bus_addr,
  input  wire logic [ipc_pkg::IPC_DATA_W-1:0]    bus_wdata,
  input  wire logic [3:0]                        bus_byte_en,
  input  wire logic                              bus_wr,
  input  wire logic                              bus_rd,
  input  wire logic                              bus_priv,
  output logic      [ipc_pkg::IPC_DATA_W-1:0]    bus_rdata,
  output logic                                   bus_err,
  // Peripheral request lines
  input  wire logic [NUM_IRQ-1:0]                irq_req,
  input  wire logic [NUM_IRQ-1:0]                irq_level_sel,
  // Core handler handshake
  input  wire logic                              core_enter,
  input  wire logic [ipc_pkg::IPC_ID_W-1:0]      core_enter_id,
  input  wire logic                              core_return,
  input  wire logic [ipc_pkg::IPC_ID_W-1:0]      core_return_id,
  output logic                                   take_valid,
  output logic      [ipc_pkg::IPC_ID_W-1:0]      take_id,
  output logic      [ipc_pkg::IPC_PRIO_W-1:0]    take_prio
);
  import ipc_pkg::*;
  // Parameter sanity
  if (NUM_IRQ < 1 || NUM_IRQ > IPC_MAX_IRQ || PRIO_BITS < 1 || PRIO_BITS > IPC_PRIO_W) begin : g_chk
    $error("ipc_irq_prio_pend: unsupported NUM_IRQ or PRIO_BITS");
  end
  localparam logic [7:0] PRIO_MASK = 8'(8'hff << (IPC_PRIO_W - PRIO_BITS));
  localparam logic [8:0] IRQ_LIMIT = 9'(NUM_IRQ);
  // Storage
  logic [IPC_PRIO_W-1:0] prio [NUM_IRQ];
  logic [NUM_IRQ-1:0]    enable;
  logic [NUM_IRQ-1:0]    req_q;
  logic                  unpriv_pend_permit;
  ipc_irq_state_type     state [NUM_IRQ];
  // Decode results
  logic                  sel_seten;
  logic                  sel_clren;
  logic                  sel_setpend;
  logic                  sel_clrpend;
  logic                  sel_active;
  logic                  sel_prio;
  logic                  sel_sysctrl;
  logic                  sel_trig;
  logic                  sel_priv_only;
  logic [IPC_VEC_W-1:0]  wr_bits;
  logic [5:0]            prio_word;
  logic [8:0]            trigger_irq_number;
  logic                  trig_ok;
  // Per-interrupt events and status
  logic [NUM_IRQ-1:0]    sw_set;
  logic [NUM_IRQ-1:0]    clr_hit;
  logic [NUM_IRQ-1:0]    enter_hit;
  logic [NUM_IRQ-1:0]    ret_hit;
  logic [IPC_VEC_W-1:0]  pend_vec;
  logic [IPC_VEC_W-1:0]  act_vec;
  logic [IPC_VEC_W-1:0]  en_vec;
  // Address decode; unmapped words read zero
  always_comb begin
    sel_seten   = 1'b0;
    sel_clren   = 1'b0;
    sel_setpend = 1'b0;
    sel_clrpend = 1'b0;
    sel_active  = 1'b0;
    sel_prio    = 1'b0;
    sel_sysctrl = 1'b0;
    sel_trig    = 1'b0;
    if (bus_addr[11:5] == IPC_SETEN_OFS[11:5]) begin
      sel_seten = 1'b1;
    end else if (bus_addr[11:5] == IPC_CLREN_OFS[11:5]) begin
      sel_clren = 1'b1;
    end else if (bus_addr[11:5] == IPC_SETPEND_OFS[11:5]) begin
      sel_setpend = 1'b1;
    end else if (bus_addr[11:5] == IPC_CLRPEND_OFS[11:5]) begin
      sel_clrpend = 1'b1;
    end else if (bus_addr[11:5] == IPC_ACTIVE_OFS[11:5]) begin
      sel_active = 1'b1;
    end else if (bus_addr >= IPC_PRIO_OFS && bus_addr <= IPC_PRIO_LAST) begin
      sel_prio = 1'b1;
    end else if (bus_addr[11:2] == IPC_SYSCTRL_OFS[11:2]) begin
      sel_sysctrl = 1'b1;
    end else if (bus_addr[11:2] == IPC_TRIG_OFS[11:2]) begin
      sel_trig = 1'b1;
    end
  end
  // Every mapped word but the trigger register is privileged
  assign sel_priv_only = sel_seten | sel_clren | sel_setpend | sel_clrpend
                       | sel_active | sel_prio | sel_sysctrl;
  assign wr_bits       = IPC_VEC_W'({224'h0, bus_wdata} << {bus_addr[4:2], 5'h00});
  assign prio_word     = bus_addr[7:2];
  assign trigger_irq_number = bus_wdata[IPC_TRIG_ID_LSB +: IPC_TRIG_ID_W];
  assign trig_ok       = bus_wr & sel_trig & (bus_priv | unpriv_pend_permit);
  // Priority array, byte lanes written independently
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < NUM_IRQ; k++) begin
        prio[k] <= IPC_PRIO_RST;
      end
    end else if (bus_wr && sel_prio && bus_priv) begin
      for (int k = 0; k < NUM_IRQ; k++) begin
        if (k[7:2] == prio_word && bus_byte_en[k[1:0]]) begin
          prio[k] <= bus_wdata[8*k[1:0] +: 8] & PRIO_MASK;
        end
      end
    end
  end
  // Enable bits; set and clear words
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      enable <= {NUM_IRQ{IPC_ENABLE_RST}};
    end else if (bus_wr && bus_priv && sel_seten) begin
      enable <= enable | wr_bits[NUM_IRQ-1:0];
    end else if (bus_wr && bus_priv && sel_clren) begin
      enable <= enable & ~wr_bits[NUM_IRQ-1:0];
    end
  end
  // Permit bit for unprivileged triggering
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      unpriv_pend_permit <= IPC_PERMIT_RST;
    end else if (bus_wr && sel_sysctrl && bus_priv) begin
      unpriv_pend_permit <= bus_wdata[IPC_PERMIT_BIT];
    end
  end
  // Request sampling for edge detection
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      req_q <= '0;
    end else begin
      req_q <= irq_req;
    end
  end
  // Per-interrupt state machines
  for (genvar i = 0; i < NUM_IRQ; i++) begin : g_irq
    logic              rise;
    logic              lvl_hold;
    logic              set_now;
    ipc_irq_state_type next_state;

    assign rise     = irq_req[i] & ~req_q[i];
    assign lvl_hold = irq_level_sel[i] & irq_req[i];
    // software set sources, out-of-range id never matches
    assign sw_set[i]    = (bus_wr & bus_priv & sel_setpend & wr_bits[i])
                        | (trig_ok & trigger_irq_number < IRQ_LIMIT
                           & trigger_irq_number == 9'(i));
    assign clr_hit[i]   = bus_wr & bus_priv & sel_clrpend & wr_bits[i];
    assign enter_hit[i] = core_enter & core_enter_id == 8'(i);
    assign ret_hit[i]   = core_return & core_return_id == 8'(i);
    // edge or software set, valid in any state
    assign set_now      = rise | sw_set[i];
    // Set always wins over a clear in the same cycle
    always_comb begin
      next_state = state[i];
      case (state[i])
        IPC_INACTIVE: begin
          // level high while not active, enable not required
          if (set_now || lvl_hold) begin
            next_state = IPC_PENDING;
          end
        end
        IPC_PENDING: begin
          if (enter_hit[i]) begin
            next_state = set_now ? IPC_ACT_PEND : IPC_ACTIVE;
          // clear ignored while level line high
          end else if (clr_hit[i] && !lvl_hold && !set_now) begin
            next_state = IPC_INACTIVE;
          end
        end
        IPC_ACTIVE: begin
          if (ret_hit[i]) begin
            next_state = (set_now || lvl_hold) ? IPC_PENDING : IPC_INACTIVE;
          end else if (set_now) begin
            next_state = IPC_ACT_PEND;
          end
        end
        IPC_ACT_PEND: begin
          if (ret_hit[i]) begin
            next_state = IPC_PENDING;
          end else if (clr_hit[i] && !lvl_hold && !set_now) begin
            next_state = IPC_ACTIVE;
          end
        end
        default: next_state = IPC_INACTIVE;
      endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        state[i] <= IPC_INACTIVE;
      end else begin
        state[i] <= next_state;
      end
    end

    assign pend_vec[i] = state[i] == IPC_PENDING || state[i] == IPC_ACT_PEND;
    assign act_vec[i]  = state[i] == IPC_ACTIVE || state[i] == IPC_ACT_PEND;
    assign en_vec[i]   = enable[i];
    // Checks on this interrupt
    sequence s_level_ret;
      ret_hit[i] && state[i] == IPC_ACTIVE && lvl_hold;
    endsequence
    sequence s_pulse_idle_ret;
      ret_hit[i] && state[i] == IPC_ACTIVE && !irq_level_sel[i] && !set_now;
    endsequence
    a_entry_active: assert property (@(posedge sys_clk) disable iff (!resetn)
      enter_hit[i] && state[i] == IPC_PENDING |=> act_vec[i] && (pend_vec[i] == $past(set_now)))
      else $error("entry did not make the interrupt active");
    a_level_return: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_level_ret |=> state[i] == IPC_PENDING)
      else $error("level return with line high not pending");
    a_pulse_repend: assert property (@(posedge sys_clk) disable iff (!resetn)
      ret_hit[i] && state[i] == IPC_ACT_PEND |=> state[i] == IPC_PENDING)
      else $error("pulse return from active-pending not pending");
    a_pulse_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_pulse_idle_ret |=> state[i] == IPC_INACTIVE)
      else $error("pulse return without pulse not inactive");
    a_level_clr_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      clr_hit[i] && lvl_hold && state[i] == IPC_PENDING && !enter_hit[i]
      |=> state[i] == IPC_PENDING)
      else $error("level clear changed state while line high");
    a_clr_keeps_act: assert property (@(posedge sys_clk) disable iff (!resetn)
      clr_hit[i] && !ret_hit[i] && act_vec[i] |=> act_vec[i])
      else $error("clear-pending dropped the active state");
    a_edge_pends: assert property (@(posedge sys_clk) disable iff (!resetn)
      !irq_req[i] ##1 irq_req[i] && state[i] == IPC_INACTIVE |=> pend_vec[i])
      else $error("rising edge did not make interrupt pending");
    a_take_enabled: assert property (@(posedge sys_clk) disable iff (!resetn)
      take_valid && take_id == 8'(i) |-> $past(enable[i]) && $past(pend_vec[i]))
      else $error("disabled or idle interrupt offered to core");
  end

  if (NUM_IRQ < IPC_VEC_W) begin : g_pad
    assign pend_vec[IPC_VEC_W-1:NUM_IRQ] = '0;
    assign act_vec[IPC_VEC_W-1:NUM_IRQ]  = '0;
    assign en_vec[IPC_VEC_W-1:NUM_IRQ]   = '0;
  end
  // Best candidate: pending, not active, enabled, lowest value, then lowest number
  logic                  next_take_valid;
  logic [IPC_ID_W-1:0]   next_take_id;
  logic [IPC_PRIO_W-1:0] next_take_prio;
  always_comb begin
    next_take_valid = 1'b0;
    next_take_id    = '0;
    next_take_prio  = '1;
    for (int k = 0; k < NUM_IRQ; k++) begin
      // strict compare keeps the lower number on ties
      if (state[k] == IPC_PENDING && enable[k]
          && (!next_take_valid || prio[k] < next_take_prio)) begin
        next_take_valid = 1'b1;
        next_take_id    = 8'(k);
        next_take_prio  = prio[k];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      take_valid <= 1'b0;
      take_id    <= '0;
      take_prio  <= '0;
    end else begin
      take_valid <= next_take_valid;
      take_id    <= next_take_id;
      take_prio  <= next_take_prio;
    end
  end
  // Read data, one cycle after the strobe
  logic [IPC_DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    if (bus_priv) begin
      if (sel_seten || sel_clren) begin
        next_rdata = en_vec[{bus_addr[4:2], 5'h00} +: 32];
      end else if (sel_setpend || sel_clrpend) begin
        next_rdata = pend_vec[{bus_addr[4:2], 5'h00} +: 32];
      end else if (sel_active) begin
        next_rdata = act_vec[{bus_addr[4:2], 5'h00} +: 32];
      end else if (sel_prio) begin
        for (int k = 0; k < NUM_IRQ; k++) begin
          if (k[7:2] == prio_word) begin
            next_rdata[8*k[1:0] +: 8] = prio[k];
          end
        end
      end else if (sel_sysctrl) begin
        next_rdata[IPC_PERMIT_BIT] = unpriv_pend_permit;
      end
    end
  end

  // Unprivileged access to a privileged word, or a refused trigger, flags an error
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus_rdata <= '0;
      bus_err   <= 1'b0;
    end else begin
      bus_rdata <= bus_rd ? next_rdata : '0;
      bus_err   <= ((bus_rd || bus_wr) && !bus_priv && sel_priv_only)
                 || (bus_wr && sel_trig && !bus_priv && !unpriv_pend_permit);
    end
  end

  // Bus level checks
  sequence s_prio_read;
    bus_rd && sel_prio && bus_priv;
  endsequence
  a_prio_low_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_prio_read |=> (bus_rdata & ~{4{PRIO_MASK}}) == 32'h0)
    else $error("unimplemented priority bits read nonzero");
  a_permit_priv: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus_wr && sel_sysctrl && !bus_priv |=> $stable(unpriv_pend_permit))
    else $error("unprivileged write changed the permit bit");
  a_trig_refused: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus_wr && sel_trig && !bus_priv && !unpriv_pend_permit |=> bus_err)
    else $error("refused trigger write not flagged");
endmodule : ipc_irq_prio_pend
`default_nettype wire

// ===== verilog/ipc_pkg.sv
// Shared constants for the interrupt priority and pending controller
`default_nettype none
package ipc_pkg;
  // Bus geometry
  localparam int          IPC_ADDR_W       = 12;
  localparam int          IPC_DATA_W       = 32;
  localparam int          IPC_ID_W         = 8;
  localparam int          IPC_MAX_IRQ      = 240;
  localparam int          IPC_VEC_W        = 256;
  // Register offsets (byte addresses)
  localparam logic [11:0] IPC_SETEN_OFS    = 12'h100;
  localparam logic [11:0] IPC_CLREN_OFS    = 12'h180;
  localparam logic [11:0] IPC_SETPEND_OFS  = 12'h200;
  localparam logic [11:0] IPC_CLRPEND_OFS  = 12'h280;
  localparam logic [11:0] IPC_ACTIVE_OFS   = 12'h300;
  localparam logic [11:0] IPC_PRIO_OFS     = 12'h400;
  localparam logic [11:0] IPC_PRIO_LAST    = 12'h4ef;
  localparam logic [11:0] IPC_SYSCTRL_OFS  = 12'hd10;
  localparam logic [11:0] IPC_TRIG_OFS     = 12'hf00;
  // Field layout
  localparam int          IPC_PRIO_W       = 8;
  localparam int          IPC_TRIG_ID_LSB  = 0;
  localparam int          IPC_TRIG_ID_W    = 9;
  localparam int          IPC_PERMIT_BIT   = 0;
  // Reset values
  localparam logic [7:0]  IPC_PRIO_RST     = 8'h00;
  localparam logic        IPC_PERMIT_RST   = 1'b0;
  localparam logic        IPC_ENABLE_RST   = 1'b0;
  // Per-interrupt state, one-hot
  typedef enum logic [3:0] {
    IPC_INACTIVE = 4'b0001,
    IPC_PENDING  = 4'b0010,
    IPC_ACTIVE   = 4'b0100,
    IPC_ACT_PEND = 4'b1000
  } ipc_irq_state_type;
endpackage : ipc_pkg
`default_nettype wire
